// file: inc/hafo_pkg.sv
// package of constants and types for the hall angle filter and offset block
package hafo_pkg;
   localparam int ANGLE_W = 16;
   localparam int BETA_W = 4;
   typedef logic [ANGLE_W-1:0] hafo_angle_t;
   typedef logic [BETA_W-1:0] hafo_beta_t;
   localparam hafo_angle_t ANGLE_ZERO = 16'h0000;
   localparam hafo_angle_t OFFSET_RST = 16'h0000;
   localparam hafo_angle_t SWITCH_RST = 16'h0000;
   localparam hafo_beta_t BETA_PASS = 4'h0;
   typedef enum logic [1:0] {
      HAFO_SEED = 2'b00,
      HAFO_RUN  = 2'b01
   } hafo_state_e;
endpackage

// file: inc/hafo_ema_if.sv
// interface between the top and one smoothing stage
`timescale 1ns/10ps
interface hafo_ema_if;
   import hafo_pkg::*;
   logic seed;
   logic step;
   hafo_angle_t target;
   hafo_beta_t beta;
   hafo_angle_t estimate;
   modport owner (output seed, output step, output target, output beta, input estimate);
   modport stage (input seed, input step, input target, input beta, output estimate);
endinterface

// file: hdl/hafo_ema.sv
// one exponential smoothing stage on a wrapping 16-bit angle
`timescale 1ns/10ps
module hafo_ema
   import hafo_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   hafo_ema_if.stage port_i
);
   typedef struct packed {
      hafo_angle_t est;
   } hafo_ema_s;

   hafo_ema_s st_r;
   hafo_ema_s st_nxt;
   logic signed [ANGLE_W-1:0] diff;
   logic signed [ANGLE_W-1:0] delta;

   always_comb begin
      st_nxt = st_r;
      // modulo subtraction gives the shortest signed step across the wrap
      diff = signed'(port_i.target - st_r.est);
      delta = diff >>> port_i.beta;
      if (port_i.seed) begin
         st_nxt.est = port_i.target;
      end else if (port_i.step) begin
         st_nxt.est = st_r.est + hafo_angle_t'(delta);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '{est: ANGLE_ZERO};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign port_i.estimate = st_r.est;
endmodule

// file: hdl/hafo_top.sv
// top of the hall angle filter and offset block
//
// Summary of operation
// - all angles are unsigned 16-bit, full turn spans the whole wrapping code range.
// - raw angle is unsmoothed; final angle is smoothed and shifted by offset.
// - offset loads on capture command; host write and adjust may also modify it.
// - offset is readable and writable; avoid writing it while angle is used.
// - slow filter uses the slow coefficient for a still magnet.
// - fast filter uses its own smaller coefficient to follow quick rotation.
// - if slow/fast outputs differ beyond threshold, final uses fast coefficient.
// - equal coefficients behave as one filter whatever the threshold.
// - zero fast coefficient passes angle through unsmoothed during fast motion.
// - invert cleared by default; clockwise rotation increases the angle.
// - invert set makes anticlockwise rotation increase the angle.
// - invert acts alike on raw and final outputs.
`timescale 1ns/10ps
module hafo_top
   import hafo_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [ANGLE_W-1:0] RAW_IN,
   input wire logic RAW_VALID,
   input wire logic REVERSE_DIR,
   input wire logic [BETA_W-1:0] SLOW_BETA,
   input wire logic [BETA_W-1:0] FAST_BETA,
   input wire logic [ANGLE_W-1:0] SWITCH_DELTA,
   input wire logic CAPTURE_OFFSET,
   input wire logic OFFSET_WR,
   input wire logic [ANGLE_W-1:0] OFFSET_WDATA,
   input wire logic OFFSET_ADJ,
   input wire logic [ANGLE_W-1:0] OFFSET_ADJ_DATA,
   output logic [ANGLE_W-1:0] RAW_ANGLE,
   output logic [ANGLE_W-1:0] FINAL_ANGLE,
   output logic [ANGLE_W-1:0] KNOB_ANGLE_OFFSET,
   output logic FAST_SELECTED,
   output logic ANGLE_VALID
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      hafo_state_e state;
      hafo_angle_t raw;
      hafo_angle_t fin;
      hafo_angle_t offset;
      logic fast_sel;
      logic valid;
   } hafo_top_s;

   hafo_top_s st_r;
   hafo_top_s st_nxt;
   hafo_ema_if slow_if ();
   hafo_ema_if fast_if ();
   hafo_angle_t raw_dir;
   hafo_angle_t shifted;
   hafo_angle_t gap;
   hafo_angle_t gap_abs;
   logic signed [ANGLE_W-1:0] fin_diff;
   hafo_beta_t fin_beta;
   hafo_angle_t fin_step;
   logic diverged;

   hafo_angle_t cap_raw;
   hafo_angle_t offset_nxt;
   logic reseed;
   logic take_seed;
   logic take_step;

   // ----------------------------------------
   // direction and offset
   // ----------------------------------------
   always_comb begin
      // direction select
      // negation mod 2^16 mirrors the sense of rotation
      raw_dir = REVERSE_DIR ? hafo_angle_t'(ANGLE_ZERO - RAW_IN) : RAW_IN;
      // offset applied, wraps at full turn
      shifted = raw_dir + st_r.offset;
      // capture reference
      // an idle raw bus carries no angle, so fall back to the last one shown
      cap_raw = RAW_VALID ? raw_dir : st_r.raw;
   end

   // ----------------------------------------
   // sample sequencing
   // ----------------------------------------
   always_comb begin
      take_seed = 1'b0;
      take_step = 1'b0;
      // only a qualified sample moves the estimators
      if (RAW_VALID) begin
         take_seed = st_r.state == HAFO_SEED;
         take_step = st_r.state == HAFO_RUN;
      end
   end

   // ----------------------------------------
   // the two estimators
   // ----------------------------------------
   // slow and fast filter stage inputs
   assign slow_if.seed = take_seed;
   assign slow_if.step = take_step;
   assign slow_if.target = shifted;
   assign slow_if.beta = SLOW_BETA;
   assign fast_if.seed = take_seed;
   assign fast_if.step = take_step;
   assign fast_if.target = shifted;
   assign fast_if.beta = FAST_BETA;

   hafo_ema u_slow (
      .clk(CLK),
      .srst(SRST),
      .port_i(slow_if.stage)
   );

   hafo_ema u_fast (
      .clk(CLK),
      .srst(SRST),
      .port_i(fast_if.stage)
   );

   // ----------------------------------------
   // filter selection and final step
   // ----------------------------------------
   always_comb begin
      // estimates and the selection are both registered, so the choice lags the samples by two cycles
      gap = slow_if.estimate - fast_if.estimate;
      gap_abs = gap[ANGLE_W-1] ? hafo_angle_t'(ANGLE_ZERO - gap) : gap;
      diverged = gap_abs > SWITCH_DELTA;
      fin_beta = st_r.fast_sel ? FAST_BETA : SLOW_BETA;
      fin_diff = signed'(shifted - st_r.fin);
      fin_step = hafo_angle_t'(fin_diff >>> fin_beta);
   end

   // ----------------------------------------
   // offset control
   // ----------------------------------------
   always_comb begin
      offset_nxt = st_r.offset;
      reseed = 1'b0;
      // capture maps the current raw angle to zero; the final angle shows it when the next sample reseeds
      // capture wins over host write and adjust in the same cycle
      if (CAPTURE_OFFSET) begin
         offset_nxt = hafo_angle_t'(ANGLE_ZERO - cap_raw);
         reseed = 1'b1;
      end else if (OFFSET_WR) begin
         offset_nxt = OFFSET_WDATA;
      end else if (OFFSET_ADJ) begin
         offset_nxt = st_r.offset + OFFSET_ADJ_DATA;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;

      if (RAW_VALID) begin
         st_nxt.raw = raw_dir;
         st_nxt.valid = 1'b1;
      end

      st_nxt.fast_sel = diverged;

      unique case (st_r.state)
         HAFO_SEED: begin
            if (RAW_VALID) begin
               // first sample seeds everything, so no long settling ramp
               st_nxt.fin = shifted;
               st_nxt.state = HAFO_RUN;
            end
         end
         HAFO_RUN: begin
            if (RAW_VALID) begin
               st_nxt.fin = st_r.fin + fin_step;
            end
         end
      endcase

      st_nxt.offset = offset_nxt;
      // a capture overrides the run transition so the next sample reseeds
      if (reseed) begin
         st_nxt.state = HAFO_SEED;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_r <= '{
            state: HAFO_SEED,
            raw: ANGLE_ZERO,
            fin: ANGLE_ZERO,
            offset: OFFSET_RST,
            fast_sel: 1'b0,
            valid: 1'b0
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // every output is a field of the state register, so none can glitch
   assign RAW_ANGLE = st_r.raw;
   assign FINAL_ANGLE = st_r.fin;
   assign KNOB_ANGLE_OFFSET = st_r.offset;
   assign FAST_SELECTED = st_r.fast_sel;
   assign ANGLE_VALID = st_r.valid;
endmodule

// file: verification/hafo_props.sv
// checker for offset, direction and filter timing at the top ports
`timescale 1ns/10ps
module hafo_props
   import hafo_pkg::*;
(
   input logic CLK,
   input logic SRST,
   input hafo_angle_t RAW_IN,
   input logic RAW_VALID,
   input logic REVERSE_DIR,
   input hafo_beta_t SLOW_BETA,
   input hafo_beta_t FAST_BETA,
   input logic CAPTURE_OFFSET,
   input logic OFFSET_WR,
   input hafo_angle_t OFFSET_WDATA,
   input logic OFFSET_ADJ,
   input hafo_angle_t OFFSET_ADJ_DATA,
   input hafo_angle_t RAW_ANGLE,
   input hafo_angle_t FINAL_ANGLE,
   input hafo_angle_t KNOB_ANGLE_OFFSET,
   input logic FAST_SELECTED,
   input logic ANGLE_VALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   logic quiet;
   assign quiet = !CAPTURE_OFFSET && !OFFSET_WR && !OFFSET_ADJ;
   chk_valid_set: assert property (RAW_VALID |=> ANGLE_VALID)
      else $error("valid flag low");
   chk_raw_fwd: assert property (RAW_VALID && !REVERSE_DIR
      |=> RAW_ANGLE == $past(RAW_IN)) else $error("raw angle wrong");
   chk_raw_rev: assert property (RAW_VALID && REVERSE_DIR
      |=> RAW_ANGLE == -$past(RAW_IN)) else $error("reversed raw wrong");
   chk_capture_load: assert property (CAPTURE_OFFSET && !RAW_VALID
      |=> KNOB_ANGLE_OFFSET == -$past(RAW_ANGLE)) else $error("capture wrong");
   chk_host_write: assert property (OFFSET_WR && !CAPTURE_OFFSET
      |=> KNOB_ANGLE_OFFSET == $past(OFFSET_WDATA)) else $error("write wrong");
   chk_offset_adj: assert property (OFFSET_ADJ && !OFFSET_WR && !CAPTURE_OFFSET
      |=> KNOB_ANGLE_OFFSET == $past(KNOB_ANGLE_OFFSET) + $past(OFFSET_ADJ_DATA))
      else $error("adjust wrong");
   chk_offset_hold: assert property (quiet |=> $stable(KNOB_ANGLE_OFFSET))
      else $error("offset moved");
   chk_pass_through: assert property (RAW_VALID && ANGLE_VALID && quiet
      && (FAST_SELECTED ? FAST_BETA : SLOW_BETA) == 4'h0
      |=> FINAL_ANGLE == RAW_ANGLE + KNOB_ANGLE_OFFSET) else $error("no pass");
endmodule

// file: verification/hafo_front.sv
// front end model handing raw angle samples to the block
`timescale 1ns/10ps
module hafo_front
   import hafo_pkg::*;
(
   input logic send,
   input hafo_angle_t angle,
   output logic raw_valid,
   output hafo_angle_t raw_in
);
   assign raw_valid = send;
   // idle bus shows the inverse so stale data is never reused
   assign raw_in = send ? angle : ~angle;
endmodule

// file: verification/hafo_top_test.sv
// self-checking bench for the angle filter and offset block
`timescale 1ns/10ps
module hafo_top_test;
   import hafo_pkg::*;
   logic CLK = '0, SRST = '1, send = '0, REVERSE_DIR = '0;
   logic CAPTURE_OFFSET = '0, OFFSET_WR = '0, OFFSET_ADJ = '0;
   logic RAW_VALID, FAST_SELECTED, ANGLE_VALID;
   hafo_beta_t SLOW_BETA = 4'h0, FAST_BETA = 4'h0;
   hafo_angle_t angle = '0, SWITCH_DELTA = '0, OFFSET_WDATA = 16'h2000;
   hafo_angle_t OFFSET_ADJ_DATA = 16'h0100, RAW_IN, RAW_ANGLE, FINAL_ANGLE, KNOB_ANGLE_OFFSET;
   int miscompares = 0, comparisons = 0;
   hafo_front fe (.send(send), .angle(angle), .raw_valid(RAW_VALID), .raw_in(RAW_IN));
   hafo_top uut (.*);
   initial forever #5 CLK = ~CLK;
   task automatic chk(string n, hafo_angle_t e, hafo_angle_t s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic sample(hafo_angle_t a);
      angle = a;
      send = '1;
      tick(1);
      send = '0;
      tick(1);
   endtask
   task automatic pulse(logic c, logic w, logic a);
      {CAPTURE_OFFSET, OFFSET_WR, OFFSET_ADJ} = {c, w, a};
      tick(1);
      {CAPTURE_OFFSET, OFFSET_WR, OFFSET_ADJ} = 3'h0;
      tick(1);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      tick(6);
      SRST = '0;
      chk("valid", 16'h0000, {15'h0000, ANGLE_VALID});
      sample(16'h1234);
      chk("raw", 16'h1234, RAW_ANGLE);
      chk("final", 16'h1234, FINAL_ANGLE);
      pulse('1, '1, '0);
      chk("capture", 16'hedcc, KNOB_ANGLE_OFFSET);
      sample(16'h1234);
      chk("zeroed", 16'h0000, FINAL_ANGLE);
      pulse('0, '1, '1);
      chk("write", 16'h2000, KNOB_ANGLE_OFFSET);
      pulse('0, '0, '1);
      chk("adjust", 16'h2100, KNOB_ANGLE_OFFSET);
      $display("test offsets done");
      REVERSE_DIR = '1;
      sample(16'h2200);
      chk("rev raw", 16'hde00, RAW_ANGLE);
      chk("rev final", 16'hff00, FINAL_ANGLE);
      $display("test reverse done");
      REVERSE_DIR = '0;
      SLOW_BETA = 4'h2;
      FAST_BETA = 4'h2;
      sample(16'h0000);
      chk("step", 16'h0780, FINAL_ANGLE);
      SLOW_BETA = 4'h4;
      FAST_BETA = 4'h0;
      SWITCH_DELTA = 16'h0010;
      repeat (3) sample(16'h8000);
      chk("fast sel", 16'h0001, {15'h0000, FAST_SELECTED});
      chk("fast final", 16'ha100, FINAL_ANGLE);
      $display("test filter done");
      report_and_stop;
   end
   initial begin
      #3000;
      miscompares++;
      report_and_stop;
   end
endmodule
bind hafo_top hafo_props chk (.*);
